// File: rtl/store_bit_flag_instr_exec.sv
// Execution unit for stores, stack, port, bit, shift and flag instructions.
// Assumes a decoder that offers one command at a time and a memory that
// returns read data in the same cycle as a registered read request.
`timescale 1ns/1ps
module store_bit_flag_instr_exec
    import store_bit_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // Command from decoder, I/O read data and ready back to decoder
    input wire logic cmd_valid_in,
    input wire cmd_t cmd_in,
    input wire logic [7:0] io_rdata_in,
    output logic cmd_ready_out,
    // Memory port
    output mem_req_t mem_req_out,
    input wire logic [7:0] mem_rdata_in,
    // System requests
    output logic wdt_restart_out,
    output logic sleep_req_out,
    // Observation
    input wire logic [4:0] dbg_sel_in,
    output logic [7:0] dbg_data_out,
    output logic [7:0] status_out,
    output logic [15:0] stack_ptr_out
);

    // Cycle count of each operation
    function automatic logic [1:0] op_cycles(input op_t op);
        case (op)
            OP_POINTER_STORE, OP_POINTER_STORE_INC, OP_POINTER_STORE_DEC, OP_DISPLACED_PTR_WRITE,
            OP_DIRECT_DATA_WRITE, OP_STACK_PUSH, OP_STACK_POP, OP_IO_BIT_FORCE_ONE,
            OP_IO_BIT_FORCE_ZERO: op_cycles = CYC_TWO;
            OP_CODE_MEMORY_FETCH, OP_LOW_POWER_HALT: op_cycles = CYC_THREE;
            default: op_cycles = CYC_ONE;
        endcase
    endfunction

    // Z, C, N, V from a shift result; other flags kept
    function automatic logic [7:0] shift_flags(input logic [7:0] status_register, input logic [7:0] res, input logic cout);
        logic [7:0] f;
        f = status_register;
        f[FLAG_Z] = (res == 8'h00);
        f[FLAG_C] = cout;
        f[FLAG_N] = res[7];
        f[FLAG_V] = res[7] ^ cout;
        shift_flags = f;
    endfunction

    // Memory request helper
    function automatic mem_req_t mreq(input logic wr, input space_t sp, input logic [15:0] a, input logic [7:0] d);
        mem_req_t m;
        m.valid = 1'b1;
        m.write = wr;
        m.space = sp;
        m.addr = a;
        m.wdata = d;
        mreq = m;
    endfunction

    logic [7:0] rf_q [REG_COUNT];
    logic [7:0] rf_d [REG_COUNT];
    logic [7:0] status_register_q, status_register_d;
    logic [15:0] sp_q, sp_d;
    exec_state_t state_q, state_d;
    logic ready_q, ready_d;
    mem_req_t mem_q, mem_d;
    logic load_q, load_d;
    logic [4:0] dest_q, dest_d;
    logic halt_q, halt_d;
    logic wdt_q, wdt_d;
    logic sleep_q, sleep_d;
    logic [7:0] dbg_q, dbg_d;
    logic [15:0] zptr;
    logic accept;

    assign zptr = {rf_q[ZH_IDX], rf_q[ZL_IDX]};
    assign accept = cmd_valid_in & ready_q;

    // Next-state and datapath
    always_comb begin
        logic [7:0] src;
        logic [7:0] mask;
        logic [7:0] res;
        logic [15:0] znew;
        src = rf_q[cmd_in.rsel];
        mask = 8'h01 << cmd_in.bsel;
        res = 8'h00;
        znew = zptr;
        rf_d = rf_q;
        status_register_d = status_register_q;
        sp_d = sp_q;
        state_d = state_q;
        mem_d = '0;
        load_d = load_q;
        dest_d = dest_q;
        halt_d = halt_q;
        wdt_d = 1'b0;
        sleep_d = 1'b0;
        dbg_d = rf_q[dbg_sel_in];
        // Read data lands one cycle after the request
        if (state_q != ST_READY && load_q) begin
            rf_d[dest_q] = mem_rdata_in;
            load_d = 1'b0;
        end
        case (state_q)
            ST_READY: begin
                if (accept) begin
                    case (op_cycles(cmd_in.op))
                        CYC_THREE: state_d = ST_MID;
                        CYC_TWO: state_d = ST_LAST;
                        default: state_d = ST_READY;
                    endcase
                    case (cmd_in.op)
                        OP_POINTER_STORE: mem_d = mreq(1'b1, SPACE_DATA, zptr, src);
                        OP_POINTER_STORE_INC: begin
                            mem_d = mreq(1'b1, SPACE_DATA, zptr, src);
                            znew = zptr + 16'h0001;
                            {rf_d[ZH_IDX], rf_d[ZL_IDX]} = znew;
                        end
                        OP_POINTER_STORE_DEC: begin
                            znew = zptr - 16'h0001;
                            mem_d = mreq(1'b1, SPACE_DATA, znew, src);
                            {rf_d[ZH_IDX], rf_d[ZL_IDX]} = znew;
                        end
                        OP_DISPLACED_PTR_WRITE: mem_d = mreq(1'b1, SPACE_DATA, zptr + cmd_in.addr, src);
                        OP_DIRECT_DATA_WRITE: mem_d = mreq(1'b1, SPACE_DATA, cmd_in.addr, src);
                        OP_CODE_MEMORY_FETCH: begin
                            mem_d = mreq(1'b0, SPACE_CODE, zptr, 8'h00);
                            load_d = 1'b1;
                            dest_d = R0_IDX;
                        end
                        OP_PORT_IN: rf_d[cmd_in.rsel] = io_rdata_in;
                        OP_PORT_OUT: mem_d = mreq(1'b1, SPACE_IO, cmd_in.addr, src);
                        OP_STACK_PUSH: begin
                            mem_d = mreq(1'b1, SPACE_DATA, sp_q, src);
                            sp_d = sp_q - 16'h0001;
                        end
                        OP_STACK_POP: begin
                            sp_d = sp_q + 16'h0001;
                            mem_d = mreq(1'b0, SPACE_DATA, sp_d, 8'h00);
                            load_d = 1'b1;
                            dest_d = cmd_in.rsel;
                        end
                        OP_IO_BIT_FORCE_ONE: mem_d = mreq(1'b1, SPACE_IO, cmd_in.addr, io_rdata_in | mask);
                        OP_IO_BIT_FORCE_ZERO: mem_d = mreq(1'b1, SPACE_IO, cmd_in.addr, io_rdata_in & ~mask);
                        OP_LOGICAL_LEFT_SHIFT: begin
                            res = {src[6:0], 1'b0};
                            rf_d[cmd_in.rsel] = res;
                            status_register_d = shift_flags(status_register_q, res, src[7]);
                        end
                        OP_LOGICAL_RIGHT_SHIFT: begin
                            res = {1'b0, src[7:1]};
                            rf_d[cmd_in.rsel] = res;
                            status_register_d = shift_flags(status_register_q, res, src[0]);
                        end
                        OP_LEFT_CARRY_ROTATE: begin
                            res = {src[6:0], status_register_q[FLAG_C]};
                            rf_d[cmd_in.rsel] = res;
                            status_register_d = shift_flags(status_register_q, res, src[7]);
                        end
                        OP_RIGHT_CARRY_ROTATE: begin
                            res = {status_register_q[FLAG_C], src[7:1]};
                            rf_d[cmd_in.rsel] = res;
                            status_register_d = shift_flags(status_register_q, res, src[0]);
                        end
                        OP_ARITH_RIGHT_SHIFT: begin
                            res = {src[7], src[7:1]};
                            rf_d[cmd_in.rsel] = res;
                            status_register_d = shift_flags(status_register_q, res, src[0]);
                        end
                        OP_NIBBLE_SWAP: rf_d[cmd_in.rsel] = {src[3:0], src[7:4]};
                        OP_FLAG_RAISE: status_register_d[cmd_in.bsel] = 1'b1;
                        OP_FLAG_DROP: status_register_d[cmd_in.bsel] = 1'b0;
                        OP_BIT_TO_TRANSFER_FLAG: status_register_d[FLAG_T] = src[cmd_in.bsel];
                        OP_TRANSFER_FLAG_TO_BIT: rf_d[cmd_in.rsel][cmd_in.bsel] = status_register_q[FLAG_T];
                        OP_LOW_POWER_HALT: halt_d = 1'b1;
                        OP_WATCHDOG_RESTART: wdt_d = 1'b1;
                        default: ;
                    endcase
                end
            end
            ST_MID: state_d = ST_LAST;
            ST_LAST: begin
                state_d = ST_READY;
                if (halt_q) begin
                    sleep_d = 1'b1;
                    halt_d = 1'b0;
                end
            end
            default: state_d = ST_READY;
        endcase
        ready_d = (state_d == ST_READY);
    end

    // State registers
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                rf_q[i] <= 8'h00;
            end
            status_register_q <= STATUS_REGISTER_RESET;
            sp_q <= SP_RESET;
            state_q <= ST_READY;
            ready_q <= 1'b1;
            mem_q <= '0;
            load_q <= 1'b0;
            dest_q <= 5'h00;
            halt_q <= 1'b0;
            wdt_q <= 1'b0;
            sleep_q <= 1'b0;
            dbg_q <= 8'h00;
        end else begin
            rf_q <= rf_d;
            status_register_q <= status_register_d;
            sp_q <= sp_d;
            state_q <= state_d;
            ready_q <= ready_d;
            mem_q <= mem_d;
            load_q <= load_d;
            dest_q <= dest_d;
            halt_q <= halt_d;
            wdt_q <= wdt_d;
            sleep_q <= sleep_d;
            dbg_q <= dbg_d;
        end
    end

    // Outputs straight from flops
    assign cmd_ready_out = ready_q;
    assign mem_req_out = mem_q;
    assign wdt_restart_out = wdt_q;
    assign sleep_req_out = sleep_q;
    assign dbg_data_out = dbg_q;
    assign status_out = status_register_q;
    assign stack_ptr_out = sp_q;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    // Named steps for command acceptance and two- and three-cycle occupancy
    sequence two_cycle_busy;
        !ready_q ##1 ready_q;
    endsequence
    sequence took(op_t o);
        accept && cmd_in.op == o;
    endsequence
    sequence three_cycle_busy;
        !ready_q [*2] ##1 ready_q;
    endsequence

    AST_PTR_INC: assert property (took(OP_POINTER_STORE_INC) |=>
        mem_q.valid && mem_q.write && mem_q.addr == $past(zptr) && zptr == $past(zptr) + 16'h0001
        ##0 two_cycle_busy) else $error("post-increment store wrong");
    AST_PTR_DEC: assert property (took(OP_POINTER_STORE_DEC) |=>
        mem_q.write && zptr == $past(zptr) - 16'h0001 && mem_q.addr == zptr ##0 two_cycle_busy)
        else $error("pre-decrement store wrong");
    AST_DISP: assert property (took(OP_DISPLACED_PTR_WRITE) |=>
        mem_q.write && mem_q.addr == $past(zptr) + $past(cmd_in.addr) && zptr == $past(zptr)
        && $stable(status_register_q)) else $error("displaced store wrong");
    AST_PUSH: assert property (took(OP_STACK_PUSH) |=>
        mem_q.write && mem_q.addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001 ##0 two_cycle_busy)
        else $error("push wrong");
    AST_POP: assert property (took(OP_STACK_POP) ##1 mem_q.valid |=>
        rf_q[$past(cmd_in.rsel, 2)] == $past(mem_rdata_in) && ready_q) else $error("pop wrong");
    AST_IO_SET: assert property (took(OP_IO_BIT_FORCE_ONE) |=>
        mem_q.write && mem_q.space == SPACE_IO && mem_q.wdata == ($past(io_rdata_in) | (8'h01 << $past(cmd_in.bsel))))
        else $error("bit force-one wrong");
    AST_ROL: assert property (took(OP_LEFT_CARRY_ROTATE) |=>
        status_register_q[FLAG_C] == $past(rf_q[cmd_in.rsel][7]) && rf_q[$past(cmd_in.rsel)][0] == $past(status_register_q[FLAG_C])
        && ready_q) else $error("rotate left wrong");
    AST_BST: assert property (took(OP_BIT_TO_TRANSFER_FLAG) |=>
        status_register_q[FLAG_T] == $past(rf_q[cmd_in.rsel][cmd_in.bsel]) && status_register_q[5:0] == $past(status_register_q[5:0]))
        else $error("bit to transfer flag wrong");
    AST_FLAG: assert property (took(OP_FLAG_RAISE) ##0 cmd_in.bsel == FLAG_S |=>
        status_register_q[FLAG_S] && status_register_q[3:0] == $past(status_register_q[3:0])) else $error("signed flag raise wrong");
    AST_HALT: assert property (took(OP_LOW_POWER_HALT) |=>
        !ready_q [*2] ##1 (ready_q && sleep_req_out && $stable(status_register_q))) else $error("halt timing wrong");
    AST_WDT: assert property (took(OP_WATCHDOG_RESTART) |=>
        wdt_restart_out && ready_q ##1 !wdt_restart_out) else $error("watchdog restart wrong");
    AST_DIRECT: assert property (took(OP_DIRECT_DATA_WRITE) |=>
        mem_q.valid && mem_q.write && mem_q.space == SPACE_DATA && mem_q.addr == $past(cmd_in.addr)
        && $stable(status_register_q) ##0 two_cycle_busy) else $error("direct store wrong");
    AST_IO_CLR: assert property (took(OP_IO_BIT_FORCE_ZERO) |=>
        mem_q.write && mem_q.space == SPACE_IO
        && mem_q.wdata == ($past(io_rdata_in) & ~(8'h01 << $past(cmd_in.bsel)))
        ##0 two_cycle_busy) else $error("bit force-zero wrong");
    AST_ROR: assert property (took(OP_RIGHT_CARRY_ROTATE) |=>
        status_register_q[FLAG_C] == $past(rf_q[cmd_in.rsel][0]) && rf_q[$past(cmd_in.rsel)][7] == $past(status_register_q[FLAG_C])
        && ready_q) else $error("rotate right wrong");
    AST_BLD: assert property (took(OP_TRANSFER_FLAG_TO_BIT) |=>
        rf_q[$past(cmd_in.rsel)][$past(cmd_in.bsel)] == $past(status_register_q[FLAG_T]) && $stable(status_register_q) && ready_q)
        else $error("transfer flag to bit wrong");
    AST_FLAG_DROP: assert property (took(OP_FLAG_DROP) |=>
        status_register_q == ($past(status_register_q) & ~(8'h01 << $past(cmd_in.bsel))) && ready_q) else $error("flag drop wrong");
    AST_FLAG_ONLY: assert property (took(OP_FLAG_RAISE) |=>
        status_register_q == ($past(status_register_q) | (8'h01 << $past(cmd_in.bsel))) && ready_q) else $error("flag raise wrong");
    AST_FETCH: assert property (took(OP_CODE_MEMORY_FETCH) |=>
        mem_q.valid && !mem_q.write && mem_q.space == SPACE_CODE && mem_q.addr == $past(zptr)
        ##0 three_cycle_busy) else $error("code fetch request wrong");
    AST_FETCH_DATA: assert property (took(OP_CODE_MEMORY_FETCH) ##1 mem_q.valid |=>
        rf_q[R0_IDX] == $past(mem_rdata_in) && $stable(status_register_q)) else $error("code fetch data wrong");
    AST_PORT_IN: assert property (took(OP_PORT_IN) |=>
        rf_q[$past(cmd_in.rsel)] == $past(io_rdata_in) && $stable(status_register_q) && ready_q) else $error("port in wrong");
    AST_IDLE: assert property (took(OP_IDLE_CYCLE) |=>
        ready_q && !mem_q.valid && $stable(status_register_q) && $stable(sp_q)) else $error("idle cycle wrong");

endmodule

// File: rtl/store_bit_pkg.sv
// Shared constants and types for the store, bit and flag execution unit.
// Assumes a single 125 MHz clock domain and an outside decoder feeding commands.
package store_bit_pkg;

    // Register file layout; the third pointer pair sits in the top two registers
    localparam int REG_COUNT = 32;
    localparam logic [4:0] R0_IDX = 5'h00;
    localparam logic [4:0] ZL_IDX = 5'h1E;
    localparam logic [4:0] ZH_IDX = 5'h1F;

    // Status register bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;

    // Reset values
    localparam logic [7:0] STATUS_REGISTER_RESET = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h0000;

    // Issue-slot cycle counts per instruction class
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    // Address spaces of the memory port
    typedef enum logic [1:0] {
        SPACE_DATA = 2'h0,
        SPACE_IO   = 2'h1,
        SPACE_CODE = 2'h2
    } space_t;

    // Operations presented by the decoder
    typedef enum logic [4:0] {
        OP_IDLE_CYCLE           = 5'h00,
        OP_POINTER_STORE        = 5'h01,
        OP_POINTER_STORE_INC    = 5'h02,
        OP_POINTER_STORE_DEC    = 5'h03,
        OP_DISPLACED_PTR_WRITE  = 5'h04,
        OP_DIRECT_DATA_WRITE    = 5'h05,
        OP_CODE_MEMORY_FETCH    = 5'h06,
        OP_PORT_IN              = 5'h07,
        OP_PORT_OUT             = 5'h08,
        OP_STACK_PUSH           = 5'h09,
        OP_STACK_POP            = 5'h0A,
        OP_IO_BIT_FORCE_ONE     = 5'h0B,
        OP_IO_BIT_FORCE_ZERO    = 5'h0C,
        OP_LOGICAL_LEFT_SHIFT   = 5'h0D,
        OP_LOGICAL_RIGHT_SHIFT  = 5'h0E,
        OP_LEFT_CARRY_ROTATE    = 5'h0F,
        OP_RIGHT_CARRY_ROTATE   = 5'h10,
        OP_ARITH_RIGHT_SHIFT    = 5'h11,
        OP_NIBBLE_SWAP          = 5'h12,
        OP_FLAG_RAISE           = 5'h13,
        OP_FLAG_DROP            = 5'h14,
        OP_BIT_TO_TRANSFER_FLAG = 5'h15,
        OP_TRANSFER_FLAG_TO_BIT = 5'h16,
        OP_LOW_POWER_HALT       = 5'h17,
        OP_WATCHDOG_RESTART     = 5'h18
    } op_t;

    // Execution phase
    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_LAST  = 2'b01,
        ST_MID   = 2'b10
    } exec_state_t;

    // Decoded command
    typedef struct packed {
        op_t op;
        logic [4:0] rsel;
        logic [2:0] bsel;
        logic [15:0] addr;
    } cmd_t;

    // Memory request towards data, I/O and code spaces
    typedef struct packed {
        logic valid;
        logic write;
        space_t space;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

endpackage

// File: dv/store_bit_flag_instr_exec_tb.sv
// Self-checking bench for the store, bit and flag execution unit.
// Assumes the unit's package is compiled first; the bench drives all ports itself.
`timescale 1ns/1ps
module store_bit_flag_instr_exec_tb import store_bit_pkg::*;;
    typedef struct {op_t op; logic [7:0] v; logic c; logic [7:0] ev; logic [7:0] ef;} row_t;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    cmd_t cmd_in = '0;
    logic [7:0] io_rdata_in = 8'h00;
    logic [7:0] mem_rdata_in = 8'h00;
    logic [4:0] dbg_sel_in = 5'h00;
    logic cmd_ready_out, wdt_restart_out, sleep_req_out;
    mem_req_t mem_req_out, req1;
    logic [7:0] dbg_data_out, status_out, rv;
    logic [15:0] stack_ptr_out;
    logic rdy1, wdt1, slp1;
    int n_errors = 0;
    int check_count = 0;
    // Shift, rotate and swap cases on r5: op, value, carry in, result, flags
    row_t rows [8] = '{
        '{OP_LOGICAL_LEFT_SHIFT, 8'h81, 1'b0, 8'h02, 8'h09}, '{OP_LOGICAL_RIGHT_SHIFT, 8'h01, 1'b0, 8'h00, 8'h0B},
        '{OP_LEFT_CARRY_ROTATE, 8'h80, 1'b1, 8'h01, 8'h09}, '{OP_LEFT_CARRY_ROTATE, 8'h40, 1'b0, 8'h80, 8'h0C},
        '{OP_RIGHT_CARRY_ROTATE, 8'h01, 1'b1, 8'h80, 8'h05}, '{OP_RIGHT_CARRY_ROTATE, 8'h02, 1'b0, 8'h01, 8'h00},
        '{OP_ARITH_RIGHT_SHIFT, 8'h81, 1'b0, 8'hC0, 8'h05}, '{OP_NIBBLE_SWAP, 8'h3C, 1'b1, 8'hC3, 8'h01}};

    store_bit_flag_instr_exec i_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cmd_valid_in(cmd_valid_in),
        .cmd_in(cmd_in), .io_rdata_in(io_rdata_in), .cmd_ready_out(cmd_ready_out), .mem_req_out(mem_req_out),
        .mem_rdata_in(mem_rdata_in), .wdt_restart_out(wdt_restart_out), .sleep_req_out(sleep_req_out),
        .dbg_sel_in(dbg_sel_in), .dbg_data_out(dbg_data_out), .status_out(status_out),
        .stack_ptr_out(stack_ptr_out));

    // Clock at 125 MHz
    always #4 ref_clk_in = ~ref_clk_in;

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Offer one command once ready, capture the first cycle after acceptance
    task automatic run(input op_t op, input logic [4:0] r, input logic [2:0] b, input logic [15:0] a,
                       input logic [7:0] io);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        while (cmd_ready_out !== 1'b1 && n < 20) begin
            @(negedge ref_clk_in);
            n++;
        end
        if (n >= 20) begin
            check(cmd_ready_out, 1'b1);
            end_of_test();
        end
        cmd_in = '{op: op, rsel: r, bsel: b, addr: a};
        io_rdata_in = io;
        cmd_valid_in = 1'b1;
        @(negedge ref_clk_in);
        cmd_valid_in = 1'b0;
        req1 = mem_req_out;
        rdy1 = cmd_ready_out;
        wdt1 = wdt_restart_out;
        slp1 = sleep_req_out;
    endtask

    // Read a register through the observation port
    task automatic rd(input logic [4:0] idx, output logic [7:0] v);
        @(negedge ref_clk_in);
        dbg_sel_in = idx;
        @(negedge ref_clk_in);
        v = dbg_data_out;
    endtask

    // Compare the captured memory request; write data only matters on writes
    task automatic chkreq(input logic v, input logic w, input space_t s, input logic [15:0] a, input logic [7:0] d);
        check({req1.valid, req1.write, req1.space, req1.addr, req1.write ? req1.wdata : 8'h00},
              {v, w, s, a, w ? d : 8'h00});
    endtask

    // Drop every status flag
    task automatic clr_flags();
        for (int b = 0; b < 8; b++) begin
            run(OP_FLAG_DROP, 5'h00, 3'(b), 16'h0000, 8'h00);
        end
    endtask

    // Hang guard
    initial begin
        #400000;
        check(32'h0, 32'h1);
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk_in);
        check({cmd_ready_out, mem_req_out.valid, status_out, stack_ptr_out}, {1'b1, 1'b0, 8'h00, 16'h0000});
        @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        $display("test reset done");
        // Load pointer 0x0100 and a source byte
        run(OP_PORT_IN, 5'h1E, 3'h0, 16'h0020, 8'h00);
        run(OP_PORT_IN, 5'h1F, 3'h0, 16'h0021, 8'h01);
        run(OP_PORT_IN, 5'h07, 3'h0, 16'h0022, 8'hA5);
        check({rdy1, req1.valid}, 2'b10);
        rd(5'h07, rv);
        check(rv, 8'hA5);
        // Table of shift, rotate and swap cases
        foreach (rows[i]) begin
            clr_flags();
            if (rows[i].c) begin
                run(OP_FLAG_RAISE, 5'h00, FLAG_C, 16'h0000, 8'h00);
            end
            run(OP_PORT_IN, 5'h05, 3'h0, 16'h0030, rows[i].v);
            run(rows[i].op, 5'h05, 3'h0, 16'h0000, 8'h00);
            check({rdy1, status_out}, {1'b1, rows[i].ef});
            rd(5'h05, rv);
            check(rv, rows[i].ev);
        end
        $display("test shift table done");
        // Each flag alone, raised then dropped
        for (int b = 0; b < 8; b++) begin
            run(OP_FLAG_RAISE, 5'h00, 3'(b), 16'h0000, 8'h00);
            check({rdy1, status_out}, {1'b1, 8'h01 << b});
            run(OP_FLAG_DROP, 5'h00, 3'(b), 16'h0000, 8'h00);
            check(status_out, 8'h00);
        end
        for (int b = 0; b < 8; b++) begin
            run(OP_FLAG_RAISE, 5'h00, 3'(b), 16'h0000, 8'h00);
        end
        $display("test flags done");
        // Pointer stores across the byte boundary of the pointer, then a direct store
        run(OP_POINTER_STORE_INC, 5'h07, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h0100, 8'hA5);
        check(rdy1, 1'b0);
        rd(5'h1E, rv);
        check(rv, 8'h01);
        run(OP_POINTER_STORE_DEC, 5'h07, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h0100, 8'hA5);
        run(OP_POINTER_STORE_DEC, 5'h07, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h00FF, 8'hA5);
        check(rdy1, 1'b0);
        run(OP_DISPLACED_PTR_WRITE, 5'h07, 3'h0, 16'h0005, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h0104, 8'hA5);
        check(rdy1, 1'b0);
        rd(5'h1F, rv);
        check(rv, 8'h00);
        rd(5'h1E, rv);
        check(rv, 8'hFF);
        run(OP_POINTER_STORE, 5'h07, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h00FF, 8'hA5);
        run(OP_DIRECT_DATA_WRITE, 5'h07, 3'h0, 16'h1234, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h1234, 8'hA5);
        check({rdy1, status_out}, {1'b0, 8'hFF});
        $display("test stores done");
        // Stack push then pop
        run(OP_STACK_PUSH, 5'h07, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_DATA, 16'h0000, 8'hA5);
        check({rdy1, stack_ptr_out}, {1'b0, 16'hFFFF});
        run(OP_STACK_POP, 5'h09, 3'h0, 16'h0000, 8'h00);
        // Read data is offered from the request cycle on and left in place
        mem_rdata_in = 8'h5A;
        chkreq(1'b1, 1'b0, SPACE_DATA, 16'h0000, 8'h00);
        check({rdy1, stack_ptr_out}, {1'b0, 16'h0000});
        rd(5'h09, rv);
        check({rv, status_out}, {8'h5A, 8'hFF});
        $display("test stack done");
        // I/O bit force and port output
        run(OP_IO_BIT_FORCE_ONE, 5'h00, 3'h1, 16'h0012, 8'hF0);
        chkreq(1'b1, 1'b1, SPACE_IO, 16'h0012, 8'hF2);
        check(rdy1, 1'b0);
        run(OP_IO_BIT_FORCE_ZERO, 5'h00, 3'h4, 16'h0013, 8'hF0);
        chkreq(1'b1, 1'b1, SPACE_IO, 16'h0013, 8'hE0);
        check({rdy1, status_out}, {1'b0, 8'hFF});
        run(OP_PORT_OUT, 5'h07, 3'h0, 16'h0033, 8'h00);
        chkreq(1'b1, 1'b1, SPACE_IO, 16'h0033, 8'hA5);
        check(rdy1, 1'b1);
        $display("test io done");
        // Code memory fetch into r0; a command offered while busy is ignored
        run(OP_CODE_MEMORY_FETCH, 5'h00, 3'h0, 16'h0000, 8'h00);
        chkreq(1'b1, 1'b0, SPACE_CODE, 16'h00FF, 8'h00);
        check(rdy1, 1'b0);
        mem_rdata_in = 8'h77;
        cmd_in = '{op: OP_PORT_IN, rsel: 5'h0B, bsel: 3'h0, addr: 16'h0040};
        io_rdata_in = 8'h99;
        @(negedge ref_clk_in);
        mem_rdata_in = 8'h00;
        cmd_valid_in = 1'b1;
        check(cmd_ready_out, 1'b0);
        @(negedge ref_clk_in);
        cmd_valid_in = 1'b0;
        check(cmd_ready_out, 1'b1);
        rd(5'h0B, rv);
        check(rv, 8'h00);
        $display("test refusal done");
        rd(5'h00, rv);
        check({rv, status_out}, {8'h77, 8'hFF});
        $display("test code fetch done");
        // Transfer flag both ways
        run(OP_FLAG_DROP, 5'h00, FLAG_T, 16'h0000, 8'h00);
        run(OP_BIT_TO_TRANSFER_FLAG, 5'h07, 3'h5, 16'h0000, 8'h00);
        check({rdy1, status_out}, {1'b1, 8'hFF});
        run(OP_BIT_TO_TRANSFER_FLAG, 5'h07, 3'h1, 16'h0000, 8'h00);
        check(status_out, 8'hBF);
        run(OP_BIT_TO_TRANSFER_FLAG, 5'h07, 3'h0, 16'h0000, 8'h00);
        run(OP_TRANSFER_FLAG_TO_BIT, 5'h08, 3'h3, 16'h0000, 8'h00);
        check({rdy1, status_out}, {1'b1, 8'hFF});
        rd(5'h08, rv);
        check(rv, 8'h08);
        $display("test transfer flag done");
        // Idle, watchdog restart and halt
        run(OP_IDLE_CYCLE, 5'h07, 3'h0, 16'h0000, 8'h00);
        check({rdy1, req1.valid, wdt1, slp1, status_out}, {4'b1000, 8'hFF});
        run(OP_WATCHDOG_RESTART, 5'h00, 3'h0, 16'h0000, 8'h00);
        check({rdy1, wdt1, status_out}, {2'b11, 8'hFF});
        @(negedge ref_clk_in);
        check(wdt_restart_out, 1'b0);
        run(OP_LOW_POWER_HALT, 5'h00, 3'h0, 16'h0000, 8'h00);
        check({rdy1, slp1}, 2'b00);
        @(negedge ref_clk_in);
        check({cmd_ready_out, sleep_req_out}, 2'b00);
        @(negedge ref_clk_in);
        check({cmd_ready_out, sleep_req_out, status_out}, {2'b11, 8'hFF});
        @(negedge ref_clk_in);
        check(sleep_req_out, 1'b0);
        $display("test system requests done");
        // Reset in mid-run clears state again
        rst_b_in = 1'b0;
        @(negedge ref_clk_in);
        check({cmd_ready_out, status_out, stack_ptr_out}, {1'b1, 8'h00, 16'h0000});
        rst_b_in = 1'b1;
        rd(5'h07, rv);
        check(rv, 8'h00);
        $display("test second reset done");
        end_of_test();
    end
endmodule
